// >>> hdl/scwh_pkg.sv
// Constants, register map, codes and types for the stepper control-word handler.
// Assumes a 40 MHz clock and a 32-bit APB register bus.
`default_nettype none
package scwh_pkg;
    // Clock rate and the longest control word processing time
    localparam int CLK_MHZ      = 40;
    localparam int CW_LIMIT_US  = 3000;
    localparam int CW_LIMIT_CYC = CW_LIMIT_US * CLK_MHZ;  // Longest time, in clock cycles (exact product)
    localparam int PROC_CYC     = 4;                      // Cycles actually spent per word
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_ACCDEC = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQST  = 8'h14;
    localparam logic [7:0] OFS_IRQMSK = 8'h18;
    // Reset values and step period limits
    localparam logic [15:0] PERIOD_RST = 16'h0064;
    localparam logic [15:0] ACCDEC_RST = 16'h0008;
    localparam logic [15:0] STOP_PER   = 16'h0400;  // Ramp ends at this period
    localparam logic [15:0] MIN_PER    = 16'h0002;
    // Status register bit positions
    localparam int ST_PROF  = 0;
    localparam int ST_BUSY  = 1;
    localparam int ST_PAUSE = 2;
    localparam int ST_EMPTY = 3;
    localparam int ST_RUN   = 4;
    localparam int ST_MODE  = 5;
    localparam int ST_CNT   = 8;
    localparam int ST_ERR   = 16;
    // Interrupt status and mask bit positions
    localparam int IRQ_QEMPTY = 0;
    localparam int IRQ_STOP   = 1;
    localparam int IRQ_BADCW  = 2;
    localparam int IRQ_REJ    = 3;
    localparam int IRQ_DONE   = 4;
    localparam int IRQ_W      = 5;
    // Command word fields: steps in [15:0]
    localparam int CMD_REV = 16;
    localparam int CMD_VEL = 17;
    localparam int CMD_W   = 18;
    // Control word numbers
    localparam logic [15:0] CW_ENABLE = 16'h0001;
    localparam logic [15:0] CW_PAUSE  = 16'h0002;
    localparam logic [15:0] CW_CONT   = 16'h0003;
    localparam logic [15:0] CW_ESTOP  = 16'h0004;
    localparam logic [15:0] CW_CSTOP  = 16'h0005;
    localparam logic [15:0] CW_STPDIR = 16'h0006;
    localparam logic [15:0] CW_CWCCW  = 16'h0007;
    // Error codes
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_BAD_WORD = 8'h07;
    // Motion sequencer states
    typedef enum logic [1:0] {RUN_IDLE, RUN_MOVE, RUN_STOP, RUN_DRAIN} scwh_run_t;
endpackage : scwh_pkg
`default_nettype wire

// >>> hdl/scwh_step_gen.sv
// Step pulse generator: one move at a time, with abort and ramp-down.
// Assumes start, abort and decel come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module scwh_step_gen
    import scwh_pkg::*;
#(
    parameter int PW = 16
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          start_i,   // Load a new move
    input  wire logic [PW-1:0] steps_i,   // Step count
    input  wire logic          rev_i,     // Reverse direction
    input  wire logic          vel_i,     // Run until stopped
    input  wire logic [PW-1:0] period_i,  // Cycles per step
    input  wire logic [PW-1:0] accdec_i,  // Period growth per step when ramping
    input  wire logic          abort_i,   // Halt at once
    input  wire logic          decel_i,   // Ramp down to rest
    output logic               busy_o,
    output logic               step_o,
    output logic               rev_o,
    output logic               done_o
);
    if (PW < 16) begin : g_bad_pw
        $error("scwh_step_gen: PW below 16");
    end

    logic [PW-1:0] cnt_q, per_q, left_q;  // Phase, period, steps left
    logic          busy_q, vel_q, rev_q, dec_q, done_q;

    // Period wrap, ramp end and last step
    wire          wrap     = busy_q && (cnt_q >= per_q - PW'(1));
    wire [PW:0]   per_up   = {1'b0, per_q} + {1'b0, accdec_i};
    wire          ramp_end = dec_q && (per_up >= {1'b0, PW'(STOP_PER)});
    wire          last     = !vel_q && !dec_q && (left_q <= PW'(1));
    wire [PW-1:0] per_ld   = (period_i < PW'(MIN_PER)) ? PW'(MIN_PER) : period_i;

    // Move sequencing
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            {busy_q, vel_q, rev_q, dec_q, done_q} <= 5'h00;
            cnt_q  <= '0;
            per_q  <= '0;
            left_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (abort_i) begin            // Immediate halt, no ramp
                busy_q <= 1'b0;
                dec_q  <= 1'b0;
            end else if (start_i) begin   // Zero-length move ends at once
                busy_q <= vel_i || (steps_i != '0);
                done_q <= !vel_i && (steps_i == '0);
                per_q  <= per_ld;
                cnt_q  <= '0;
                left_q <= steps_i;
                vel_q  <= vel_i;
                rev_q  <= rev_i;
                dec_q  <= 1'b0;
            end else begin
                if (decel_i && busy_q) begin
                    dec_q <= 1'b1;
                end
                if (wrap) begin           // One step period elapsed
                    cnt_q  <= '0;
                    left_q <= left_q - PW'(1);
                    if (dec_q) begin
                        per_q <= per_up[PW-1:0];
                    end
                    if (last || ramp_end) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        dec_q  <= 1'b0;
                    end
                end else if (busy_q) begin
                    cnt_q <= cnt_q + PW'(1);
                end
            end
        end
    end

    // Step high for the first half of each period
    assign step_o = busy_q && (cnt_q < (per_q >> 1));
    assign busy_o = busy_q;
    assign rev_o  = rev_q;
    assign done_o = done_q;
endmodule : scwh_step_gen
`default_nettype wire

// >>> hdl/scwh_ctrl_top.sv
// Control-word handler of a stepper pulse output, with APB registers.
// Assumes an APB master on ref_clk_i and a stepper drive on the two outputs.
// How it works
// - Word 1 enables profile; queue accepts then only.
// - Word 2 pauses: no queued command starts.
// - Pause lets the running move finish.
// - Word 3 clears pause, runs next command.
// - Resume during a move with a queued command aborts it.
// - Resume on empty queue: flag, ramp stop.
// - Word 4 halts pulses at once, flushes.
// - Word 5 ramps to rest, flushes queue.
// - Word 6 selects step and direction outputs.
// - Step and direction mode after reset.
// - Word 7 selects separate forward/reverse pulses.
// - Word processed within 3 ms, busy flag.
// - Profile clear halts pulses, empties queue.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module scwh_ctrl_top
    import scwh_pkg::*;
#(
    parameter int QDEPTH    = 4,            // Command queue depth
    parameter int CW_LIMIT  = CW_LIMIT_CYC, // Longest processing time, cycles
    parameter int PROC_DLY  = PROC_CYC      // Processing time actually used
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    output logic             step_cw_o,
    output logic             dir_ccw_o
);
    localparam int QW = $clog2(QDEPTH);

    if (QDEPTH < 2 || QDEPTH > 16 || (1 << QW) != QDEPTH) begin : g_bad_q
        $error("scwh_ctrl_top: QDEPTH must be a power of two, 2 to 16");
    end
    if (PROC_DLY < 1 || PROC_DLY > 15 || PROC_DLY > CW_LIMIT) begin : g_bad_proc
        $error("scwh_ctrl_top: PROC_DLY must be 1 to 15 and within CW_LIMIT");
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Register address match
    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction : hit

    // Bus answer and register state
    logic                pready_q, pslverr_q;
    logic [31:0]         prdata_q;
    logic [15:0]         cw_num_q;        // Last control word number
    logic                cw_pend_q;       // Word not yet processed
    logic [3:0]          proc_cnt_q;      // Processing time counter
    logic                prof_en_q;       // Profile enabled
    logic                paused_q;        // Pause flag
    logic                cw_mode_q;       // 0 step/dir, 1 cw/ccw
    logic [7:0]          err_q;           // Last error code
    logic [15:0]         period_q;        // Run speed, cycles per step
    logic [15:0]         accdec_q;        // Ramp rate
    logic [IRQ_W-1:0]    irq_stat_q;      // Sticky events
    logic [IRQ_W-1:0]    irq_mask_q;      // Event enables
    logic                irq_q, step_cw_q, dir_ccw_q;
    scwh_run_t           run_q, run_d;    // Motion sequencer
    logic [CMD_W-1:0]    q_mem [QDEPTH];  // Command queue storage
    logic [QW-1:0]       wr_ptr_q, rd_ptr_q;
    logic [QW:0]         q_cnt_q;         // Entries held

    // Sequencer strobes
    logic gen_start, gen_abort, gen_decel, flush, pop, stop_done, qempty_ev;
    wire  gen_busy, gen_step, gen_rev, gen_done;

    // APB decode: the write lands at the edge that samples pready high
    wire acc      = psel_i && penable_i && pready_q;
    wire wr       = acc && pwrite_i;
    wire sel_ctrl = hit(paddr_i, OFS_CTRL);
    wire sel_cmd  = hit(paddr_i, OFS_CMD);
    wire sel_per  = hit(paddr_i, OFS_PERIOD);
    wire sel_acc  = hit(paddr_i, OFS_ACCDEC);
    wire sel_st   = hit(paddr_i, OFS_STATUS);
    wire sel_ist  = hit(paddr_i, OFS_IRQST);
    wire sel_imk  = hit(paddr_i, OFS_IRQMSK);
    wire mapped   = sel_ctrl | sel_cmd | sel_per | sel_acc | sel_st | sel_ist | sel_imk;
    wire wr_ctrl  = wr && sel_ctrl && !cw_pend_q;  // Word sent while busy is dropped
    wire wr_cmd   = wr && sel_cmd;

    // Control word execution strobes
    wire cw_exec  = cw_pend_q && (proc_cnt_q == 4'(PROC_DLY - 1));
    wire cw_valid = (cw_num_q >= CW_ENABLE) && (cw_num_q <= CW_CWCCW);
    wire bad_cw   = cw_exec && !cw_valid;
    wire ex_en    = cw_exec && (cw_num_q == CW_ENABLE);
    wire ex_pause = cw_exec && (cw_num_q == CW_PAUSE);
    wire ex_cont  = cw_exec && (cw_num_q == CW_CONT);
    wire ex_estop = cw_exec && (cw_num_q == CW_ESTOP);
    wire ex_cstop = cw_exec && (cw_num_q == CW_CSTOP);
    wire ex_sd    = cw_exec && (cw_num_q == CW_STPDIR);
    wire ex_cc    = cw_exec && (cw_num_q == CW_CWCCW);
    wire prof_clr = ex_estop || bad_cw || stop_done;

    // Queue push only while the profile is enabled and room remains
    wire q_full   = (q_cnt_q == (QW+1)'(QDEPTH));
    wire q_empty  = (q_cnt_q == '0);
    wire push     = wr_cmd && prof_en_q && !q_full && !flush;
    wire rej      = wr_cmd && !push;
    wire [CMD_W-1:0] q_head = q_mem[rd_ptr_q];

    // Events and read data
    wire [IRQ_W-1:0] ev = {gen_done && (run_q == RUN_MOVE), rej, bad_cw, stop_done,
                           qempty_ev};
    wire [31:0] status_w = {8'h00, err_q, 3'h0, 5'(q_cnt_q), 2'h0, cw_mode_q,
                            gen_busy, q_empty, paused_q, cw_pend_q, prof_en_q};
    wire [31:0] rdata_w = sel_ctrl ? {16'h0000, cw_num_q} :
                          sel_per  ? {16'h0000, period_q} :
                          sel_acc  ? {16'h0000, accdec_q} :
                          sel_st   ? status_w :
                          sel_ist  ? {27'h0, irq_stat_q} :
                          sel_imk  ? {27'h0, irq_mask_q} : 32'h00000000;

    // Bus answer: one wait state, error on unmapped address
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel_i && penable_i && !pready_q;
            pslverr_q <= psel_i && penable_i && !pready_q && !mapped;
            prdata_q  <= rdata_w;
        end
    end

    // Control word capture and processing time
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cw_num_q   <= 16'h0000;
            cw_pend_q  <= 1'b0;
            proc_cnt_q <= 4'h0;
        end else if (wr_ctrl) begin       // Busy until processed
            cw_num_q   <= pwdata_i[15:0];
            cw_pend_q  <= 1'b1;
            proc_cnt_q <= 4'h0;
        end else if (cw_exec) begin
            cw_pend_q  <= 1'b0;
        end else if (cw_pend_q) begin
            proc_cnt_q <= proc_cnt_q + 4'h1;
        end
    end

    // Software-written speed, ramp and interrupt mask settings
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            period_q   <= PERIOD_RST;
            accdec_q   <= ACCDEC_RST;
            irq_mask_q <= '0;
        end else begin
            if (wr && sel_per) period_q <= pwdata_i[15:0];
            if (wr && sel_acc) accdec_q <= pwdata_i[15:0];
            if (wr && sel_imk) irq_mask_q <= pwdata_i[IRQ_W-1:0];
        end
    end

    // Profile, pause, mode and error flags
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prof_en_q <= 1'b0;
            paused_q  <= 1'b0;
            cw_mode_q <= 1'b0;            // Step/direction by default
            err_q     <= ERR_NONE;
        end else begin
            if (prof_clr) prof_en_q <= 1'b0;
            else if (ex_en) prof_en_q <= 1'b1;
            if (ex_pause) paused_q <= 1'b1;
            else if (ex_cont) paused_q <= 1'b0;
            if (ex_sd) cw_mode_q <= 1'b0;
            else if (ex_cc) cw_mode_q <= 1'b1;
            if (bad_cw) err_q <= ERR_BAD_WORD;
            else if (cw_exec) err_q <= ERR_NONE;
        end
    end

    // Motion sequencer: queue start, then control word overrides
    always_comb begin
        run_d     = run_q;
        gen_start = 1'b0;
        gen_abort = 1'b0;
        gen_decel = 1'b0;
        flush     = 1'b0;
        pop       = 1'b0;
        stop_done = 1'b0;
        qempty_ev = 1'b0;
        case (run_q)
            RUN_IDLE: begin                         // Paused queue holds
                if (prof_en_q && !paused_q && !q_empty && !cw_exec) begin
                    gen_start = 1'b1;
                    pop       = 1'b1;
                    run_d     = RUN_MOVE;
                end
            end
            RUN_MOVE: begin                         // Runs on through pause
                if (gen_done) run_d = RUN_IDLE;
            end
            RUN_STOP: begin                         // Stop complete ends profile
                if (!gen_busy) begin
                    stop_done = 1'b1;
                    flush     = 1'b1;
                    run_d     = RUN_IDLE;
                end
            end
            RUN_DRAIN: begin
                if (!gen_busy) run_d = RUN_IDLE;
            end
            default: run_d = RUN_IDLE;
        endcase
        if (ex_cont) begin
            if (q_empty) begin                      // Nothing left: ramp down
                qempty_ev = 1'b1;
                if (run_q == RUN_MOVE) begin
                    gen_decel = 1'b1;
                    run_d     = RUN_DRAIN;
                end
            end else if (run_q == RUN_MOVE) begin   // Cut move short
                gen_abort = 1'b1;
                run_d     = RUN_IDLE;
            end
        end
        if (ex_estop || bad_cw) begin               // Halt now, flush
            gen_abort = 1'b1;
            flush     = 1'b1;
            stop_done = 1'b0;
            run_d     = RUN_IDLE;
        end
        if (ex_cstop) begin                         // Ramp to rest, flush
            flush = 1'b1;
            if (run_q != RUN_IDLE) begin
                gen_decel = 1'b1;
                run_d     = RUN_STOP;
            end else begin
                stop_done = 1'b1;
            end
        end
    end

    // Sequencer state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) run_q <= RUN_IDLE;
        else run_q <= run_d;
    end

    // Command queue pointers; flush wins over push and pop
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            q_cnt_q  <= '0;
        end else begin
            if (push) wr_ptr_q <= wr_ptr_q + QW'(1);
            if (pop) rd_ptr_q <= rd_ptr_q + QW'(1);
            if (push && !pop) q_cnt_q <= q_cnt_q + (QW+1)'(1);
            else if (pop && !push) q_cnt_q <= q_cnt_q - (QW+1)'(1);
        end
    end

    // Queue storage, no reset needed
    always_ff @(posedge ref_clk_i) begin
        if (push) q_mem[wr_ptr_q] <= pwdata_i[CMD_W-1:0];
    end

    // Sticky events: a new event beats a write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr && sel_ist) ? pwdata_i[IRQ_W-1:0] : '0)) | ev;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Pulse generator
    scwh_step_gen #(.PW(16)) u_gen (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (gen_start),
        .steps_i   (q_head[15:0]),
        .rev_i     (q_head[CMD_REV]),
        .vel_i     (q_head[CMD_VEL]),
        .period_i  (period_q),
        .accdec_i  (accdec_q),
        .abort_i   (gen_abort),
        .decel_i   (gen_decel),
        .busy_o    (gen_busy),
        .step_o    (gen_step),
        .rev_o     (gen_rev),
        .done_o    (gen_done)
    );

    // Output pin mapping per mode
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            step_cw_q <= 1'b0;
            dir_ccw_q <= 1'b0;
        end else if (cw_mode_q) begin               // Separate pulse lines
            step_cw_q <= gen_step && !gen_rev;
            dir_ccw_q <= gen_step && gen_rev;
        end else begin                              // Step plus level
            step_cw_q <= gen_step;
            dir_ccw_q <= gen_rev;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o     = irq_q;
    assign step_cw_o = step_cw_q;
    assign dir_ccw_o = dir_ccw_q;

    // Checks
    sequence s_exec(logic [15:0] n);
        cw_exec && (cw_num_q == n);
    endsequence
    sequence s_busy_window;
        cw_pend_q ##[1:16] !cw_pend_q;
    endsequence

    a_cw_busy_flag: assert property (wr_ctrl |=> s_busy_window)
        else $error("control word busy flag wrong");
    a_cw_done_time: assert property (cw_pend_q |-> ##[0:16] cw_exec)
        else $error("control word not processed in time");
    a_push_gated: assert property (wr_cmd && !prof_en_q |=> q_cnt_q <= $past(q_cnt_q))
        else $error("command queued while profile disabled");
    a_pause_block: assert property (paused_q |-> !gen_start)
        else $error("command started while paused");
    a_pause_finish: assert property (paused_q && !cw_exec |-> !gen_abort)
        else $error("running move cut by pause");
    a_resume_next: assert property (s_exec(CW_CONT) and (run_q == RUN_MOVE && !q_empty)
        |-> gen_abort ##1 (run_q == RUN_IDLE && gen_start))
        else $error("resume did not move to next command");
    a_resume_empty: assert property (s_exec(CW_CONT) and q_empty
        |=> irq_stat_q[IRQ_QEMPTY] && run_q != RUN_MOVE)
        else $error("resume on empty queue mishandled");
    a_estop_halt: assert property (s_exec(CW_ESTOP) |=> !gen_busy && q_empty && !prof_en_q)
        else $error("emergency stop did not halt");
    a_cstop_ramp: assert property (s_exec(CW_CSTOP) and (run_q == RUN_MOVE)
        |=> run_q == RUN_STOP && q_empty)
        else $error("controlled stop did not ramp");
    a_stop_clear: assert property (run_q == RUN_STOP && !gen_busy && !cw_exec
        |=> !prof_en_q && q_empty)
        else $error("stop completion left profile enabled");
    a_mode_stepdir: assert property (!cw_mode_q |=> step_cw_o == $past(gen_step))
        else $error("step output wrong in step/direction mode");
    a_mode_cwccw: assert property (cw_mode_q |=> dir_ccw_o == $past(gen_step && gen_rev))
        else $error("reverse pulse wrong in cw/ccw mode");
    a_bad_word: assert property (bad_cw |=> err_q == ERR_BAD_WORD
        && cw_mode_q == $past(cw_mode_q) && paused_q == $past(paused_q))
        else $error("invalid control number not rejected");
endmodule : scwh_ctrl_top
`default_nettype wire

// >>> verif/scwh_drive_model.sv
// Stepper drive stand-in: counts pulse rises on both pin lines.
// Assumes the handler's pins are registered on ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module scwh_drive_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        step_cw_i,  // Step or forward pulse
    input  wire logic        dir_ccw_i,  // Direction or reverse pulse
    output var  logic [31:0] cw_cnt_o,   // Rises on step/cw
    output var  logic [31:0] ccw_cnt_o   // Rises on direction/ccw
);
    logic cw_q, ccw_q;  // Previous line levels
    // Edge counters, cleared by reset
    always_ff @(posedge ref_clk_i) begin
        cw_q  <= step_cw_i;
        ccw_q <= dir_ccw_i;
        if (!rst_n_i) begin
            cw_cnt_o  <= 32'h0;
            ccw_cnt_o <= 32'h0;
        end else begin
            if (step_cw_i && !cw_q) cw_cnt_o <= cw_cnt_o + 32'h1;
            if (dir_ccw_i && !ccw_q) ccw_cnt_o <= ccw_cnt_o + 32'h1;
        end
    end
endmodule : scwh_drive_model
`default_nettype wire

// >>> verif/test_stepper_control_word_handler.sv
// Bench: APB driver noting expected answers, drive model on the pins.
// Assumes the scwh_pkg map; processing limit shortened to 16 cycles.
`timescale 1ns/10ps
`default_nettype none
module test_stepper_control_word_handler;
    import scwh_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic x;} scwh_note_t;
    localparam int CWL = 16;
    logic        ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
    logic [31:0] paddr_i, pwdata_i, prdata_o, rd, seed, k, a0, b0, cw_n, ccw_n;
    logic        pready_o, pslverr_o, irq_o, step_cw_o, dir_ccw_o;
    int          error_cnt, compares, cyc;
    logic [15:0] bad[2] = '{16'h0000, 16'h0009};  // Illegal numbers
    scwh_note_t  notes[$];                        // Expected APB answers
    scwh_ctrl_top #(.CW_LIMIT(CWL)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .irq_o(irq_o), .step_cw_o(step_cw_o), .dir_ccw_o(dir_ccw_o));
    scwh_drive_model drv (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .step_cw_i(step_cw_o),
        .dir_ccw_i(dir_ccw_o), .cw_cnt_o(cw_n), .ccw_cnt_o(ccw_n));
    task automatic summarize();
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; the note is checked by the monitor
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] e, logic [31:0] m);
        @(posedge ref_clk_i);
        notes.push_back(scwh_note_t'{e, m, a > 8'h18 || a[1:0] != 2'h0});
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= {24'h0, a};
        pwdata_i <= d;
        @(posedge ref_clk_i) penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic w(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0);
    endtask : w
    task automatic r(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        apb(1'b0, a, 32'h0, e, m);
    endtask : r
    // Control word, then busy must clear within the limit
    task automatic cw(logic [15:0] n);
        w(OFS_CTRL, {16'h0, n});
        rd = '1;
        for (int i = 0; i < CWL / 4 && rd[ST_BUSY] !== 1'b0; i++) begin
            r(OFS_STATUS, 32'h0, 32'h0);
        end
        chk("busy", 32'h0, {31'h0, rd[ST_BUSY]});
    endtask : cw
    // Poll an event bit, then clear it by writing one
    task automatic wirq(int b);
        rd = '0;
        for (int i = 0; i < 1200 && rd[b] !== 1'b1; i++) r(OFS_IRQST, 32'h0, 32'h0);
        chk("event", 32'h1, {31'h0, rd[b]});
        w(OFS_IRQST, 32'h1 << b);
    endtask : wirq
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Answer monitor and hang limit
    always @(posedge ref_clk_i) begin
        cyc++;
        if (pready_o === 1'b1 && notes.size() > 0) begin
            chk("prdata", notes[0].e, prdata_o & notes[0].m);
            chk("pslverr", {31'h0, notes[0].x}, {31'h0, pslverr_o});
            void'(notes.pop_front());
        end
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        seed = 32'h5debcfae;
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        r(OFS_PERIOD, 32'h64, 32'hffff);
        r(OFS_STATUS, 32'h8, 32'h2d);
        r(8'h40, 32'h0, '1);
        w(OFS_CMD, 32'h1);
        wirq(IRQ_REJ);
        w(OFS_PERIOD, 32'h4);
        w(OFS_ACCDEC, 32'h100);
        cw(CW_ENABLE);
        k = 32'h1 + xs() % 32'h8;
        w(OFS_CMD, 32'h10000 | k);
        wirq(IRQ_DONE);
        chk("steps", k, cw_n);
        chk("dir", 32'h1, ccw_n);
        cw(CW_CWCCW);
        {a0, b0} = {cw_n, ccw_n};
        w(OFS_CMD, 32'h10003);
        wirq(IRQ_DONE);
        chk("ccw", 32'h3, ccw_n - b0);
        chk("cw", a0, cw_n);
        cw(CW_STPDIR);
        r(OFS_STATUS, 32'h0, 32'h20);
        a0 = cw_n;
        w(OFS_CMD, 32'h6);
        cw(CW_PAUSE);
        wirq(IRQ_DONE);
        w(OFS_CMD, 32'h2);
        repeat (40) @(posedge ref_clk_i);
        chk("paused", 32'h6, cw_n - a0);
        cw(CW_CONT);
        wirq(IRQ_DONE);
        chk("resumed", 32'h8, cw_n - a0);
        cw(CW_CONT);
        wirq(IRQ_QEMPTY);
        w(OFS_CMD, 32'h20000);
        w(OFS_CMD, 32'h3);
        cw(CW_CONT);
        wirq(IRQ_DONE);
        // Resume on an empty queue during a move: ramp to rest, profile kept
        w(OFS_CMD, 32'h20000);
        cw(CW_CONT);
        wirq(IRQ_QEMPTY);
        repeat (1800) @(posedge ref_clk_i);
        r(OFS_STATUS, 32'h1, 32'h11);
        w(OFS_CMD, 32'h20000);
        cw(CW_ESTOP);
        a0 = cw_n;
        repeat (40) @(posedge ref_clk_i);
        chk("halt", a0, cw_n);
        r(OFS_STATUS, 32'h8, 32'h1f19);
        cw(CW_ENABLE);
        w(OFS_CMD, 32'h20000);
        w(OFS_CMD, 32'h20000);
        cw(CW_CSTOP);
        a0 = cw_n;
        wirq(IRQ_STOP);
        chk("ramp", 32'h1, {31'h0, cw_n > a0});
        r(OFS_STATUS, 32'h8, 32'h1f19);
        cw(CW_CWCCW);
        w(OFS_IRQMSK, 32'h1 << IRQ_BADCW);
        foreach (bad[i]) begin
            cw(bad[i]);
            r(OFS_STATUS, 32'h70020, 32'hff0021);
            chk("irq", 32'h1, {31'h0, irq_o});
            wirq(IRQ_BADCW);
            repeat (2) @(posedge ref_clk_i);
            chk("irq_clr", 32'h0, {31'h0, irq_o});
        end
        summarize();
    end
endmodule : test_stepper_control_word_handler
`default_nettype wire
